// *** charger_status_fault_regs.sv ***
// Function
// - Writing one to force-port-detect starts detection with power; clears when done.
// - Half-rate enable halves safety timer speed during input limiting or thermal regulation.
// - Battery-switch-off bit forces the battery switch off; zero allows it on.
// - Upper interrupt enable gates charge fault interrupts; resets to one.
// - Lower interrupt enable gates battery overvoltage interrupts; resets to one.
// - Input source type reads none, USB host, adapter or boost.
// - Charge phase reads idle, precharge, fast charge or done.
// - Input-limit-active reads one while voltage or current input limit regulates.
// - Input power good reads one when the source qualifies.
// - Thermal-limit-active reads one during thermal regulation.
// - Minimum-system bit reads one while battery sits below minimum system voltage.
// - Host-timeout fault latches when the watchdog expires.
// - Boost fault latches on overload, input overvoltage or battery too low.
// - Charge fault code latches input, thermal shutdown or timer expiry.
// - Battery overvoltage fault latches on detection.
// - Thermistor fault bit one is cold, bit zero hot, thresholds per mode.
// - Faults latch; a read returns and clears them, then shows live faults.
// - Adapter removal sets the charge fault code to input fault once.
// - Identification register is read-only: part code, two zeros, revision.
`timescale 1ns/10ps
`default_nettype none

module charger_status_fault_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Live status from the analog side
  input wire logic [1:0] input_source_type_i,
  input wire logic [1:0] charge_phase_i,
  input wire logic input_voltage_limit_i,
  input wire logic input_current_limit_i,
  input wire logic input_power_good_i,
  input wire logic thermal_limit_active_i,
  input wire logic min_system_reg_active_i,
  input wire logic vbus_present_i,
  input wire logic port_detect_done_i,
  // Live fault causes
  input wire logic watchdog_expired_i,
  input wire logic boost_overload_i,
  input wire logic vbus_ovp_i,
  input wire logic boost_battery_low_i,
  input wire logic input_fault_i,
  input wire logic thermal_shutdown_i,
  input wire logic timer_expired_i,
  input wire logic battery_overvoltage_i,
  input wire logic boost_mode_i,
  input wire logic cold_buck_i,
  input wire logic hot_buck_i,
  input wire logic cold_boost_i,
  input wire logic hot_boost_i,
  // Safety timer prescaler tick, same clock
  input wire logic safety_timer_tick_i,
  // Controls to the charger
  output logic port_detect_req_o,
  output logic safety_timer_adv_o,
  output logic battery_switch_off_o,
  output logic fault_int_o
);

  logic [charger_regs_pkg::SYNC_W-1:0] raw;
  logic [charger_regs_pkg::SYNC_W-1:0] syn;
  logic scl_s;
  logic sda_s;
  logic [1:0] src_s;
  logic [1:0] phase_s;
  logic vin_s;
  logic iin_s;
  logic pg_s;
  logic therm_s;
  logic minsys_s;
  logic vbus_s;
  logic done_s;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  charger_regs_pkg::serial_state_type state_q;

  assign raw = {scl_i, sda_i, input_source_type_i, charge_phase_i, input_voltage_limit_i,
                input_current_limit_i, input_power_good_i, thermal_limit_active_i,
                min_system_reg_active_i, vbus_present_i, port_detect_done_i,
                watchdog_expired_i, boost_overload_i, vbus_ovp_i, boost_battery_low_i,
                input_fault_i, thermal_shutdown_i, timer_expired_i, battery_overvoltage_i,
                boost_mode_i, cold_buck_i, hot_buck_i, cold_boost_i, hot_boost_i};

  sync_2ff #(
    .WIDTH(charger_regs_pkg::SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(raw),
    .sync_o(syn)
  );

  assign scl_s = syn[25];
  assign sda_s = syn[24];
  assign src_s = syn[23:22];
  assign phase_s = syn[21:20];
  assign vin_s = syn[19];
  assign iin_s = syn[18];
  assign pg_s = syn[17];
  assign therm_s = syn[16];
  assign minsys_s = syn[15];
  assign vbus_s = syn[14];
  assign done_s = syn[13];

  // Register file
  logic [7:0] misc_q;
  logic [7:0] status;
  logic [7:0] fault;
  logic [7:0] ident;
  logic fault_clear;
  logic new_charge;
  logic new_bat;
  logic new_other;

  assign status = {src_s, phase_s, vin_s | iin_s, pg_s, therm_s, minsys_s};
  assign ident = {charger_regs_pkg::PART_CODE, charger_regs_pkg::ID_RESERVED,
                  charger_regs_pkg::REV_CODE};

  fault_capture u_fault (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .watchdog_expired_i(syn[12]),
    .boost_any_fault_i(syn[11] | syn[10] | syn[9]),
    .input_fault_i(syn[8]),
    .thermal_shutdown_i(syn[7]),
    .timer_expired_i(syn[6]),
    .battery_ov_i(syn[5]),
    .boost_mode_i(syn[4]),
    .cold_buck_i(syn[3]),
    .hot_buck_i(syn[2]),
    .cold_boost_i(syn[1]),
    .hot_boost_i(syn[0]),
    .vbus_present_i(vbus_s),
    .clear_i(fault_clear),
    .fault_o(fault),
    .new_charge_o(new_charge),
    .new_bat_o(new_bat),
    .new_other_o(new_other)
  );

  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] m,
                                          input logic [7:0] s, input logic [7:0] f,
                                          input logic [7:0] i);
    case (addr)
      charger_regs_pkg::OFF_MISC: reg_read = m;
      charger_regs_pkg::OFF_STATUS: reg_read = s;
      charger_regs_pkg::OFF_FAULT: reg_read = f;
      charger_regs_pkg::OFF_ID: reg_read = i;
      default: reg_read = charger_regs_pkg::READ_NONE;
    endcase
  endfunction : reg_read

  // Serial slave
  logic [2:0] bit_cnt_q;
  logic byte_done_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic sda_oe_q;
  logic wr_en_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic load_rd;
  logic [7:0] rd_data;

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
  assign rd_data = reg_read(ptr_q, misc_q, status, fault, ident);
  assign load_rd = scl_fall & (((state_q == charger_regs_pkg::ST_ADDR_ACK) & rw_q) |
                               (state_q == charger_regs_pkg::ST_RACK));
  // Each byte leaving the fault register clears it, hence single-byte reads
  assign fault_clear = load_rd & (ptr_q == charger_regs_pkg::OFF_FAULT);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= charger_regs_pkg::ST_IDLE;
      bit_cnt_q <= 3'h0;
      byte_done_q <= 1'b0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= 1'b0;
      if (start_cond) begin
        state_q <= charger_regs_pkg::ST_ADDR;
        bit_cnt_q <= 3'h0;
        byte_done_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_cond) begin
        state_q <= charger_regs_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          charger_regs_pkg::ST_ADDR, charger_regs_pkg::ST_PTR, charger_regs_pkg::ST_WDATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              byte_done_q <= (bit_cnt_q == charger_regs_pkg::BIT_LAST);
            end else if (scl_fall && byte_done_q) begin
              byte_done_q <= 1'b0;
              if (state_q == charger_regs_pkg::ST_ADDR) begin
                if (shift_q[7:1] == charger_regs_pkg::SLAVE_ADDR) begin
                  rw_q <= shift_q[0];
                  sda_oe_q <= 1'b1;
                  state_q <= charger_regs_pkg::ST_ADDR_ACK;
                end else begin
                  state_q <= charger_regs_pkg::ST_IDLE;
                end
              end else if (state_q == charger_regs_pkg::ST_PTR) begin
                ptr_q <= shift_q;
                sda_oe_q <= 1'b1;
                state_q <= charger_regs_pkg::ST_PTR_ACK;
              end else begin
                wr_en_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q <= ptr_q + 8'h01;
                sda_oe_q <= 1'b1;
                state_q <= charger_regs_pkg::ST_WDATA_ACK;
              end
            end
          end
          charger_regs_pkg::ST_ADDR_ACK, charger_regs_pkg::ST_PTR_ACK,
          charger_regs_pkg::ST_WDATA_ACK: begin
            if (scl_fall) begin
              if (load_rd) begin
                shift_q <= rd_data;
                sda_oe_q <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= charger_regs_pkg::ST_RDATA;
              end else begin
                sda_oe_q <= 1'b0;
                state_q <= (state_q == charger_regs_pkg::ST_ADDR_ACK) ?
                           charger_regs_pkg::ST_PTR : charger_regs_pkg::ST_WDATA;
              end
            end
          end
          charger_regs_pkg::ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 3'h1;
              byte_done_q <= (bit_cnt_q == charger_regs_pkg::BIT_LAST);
            end else if (scl_fall && byte_done_q) begin
              byte_done_q <= 1'b0;
              sda_oe_q <= 1'b0;
              state_q <= charger_regs_pkg::ST_RACK;
            end else if (scl_fall) begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_q <= ~shift_q[6];
            end
          end
          charger_regs_pkg::ST_RACK: begin
            // Master not-acknowledge ends the read
            if (scl_rise && sda_s) begin
              state_q <= charger_regs_pkg::ST_IDLE;
            end else if (load_rd) begin
              shift_q <= rd_data;
              sda_oe_q <= ~rd_data[7];
              ptr_q <= ptr_q + 8'h01;
              state_q <= charger_regs_pkg::ST_RDATA;
            end
          end
          default: begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  // Control register; only its own index takes writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      misc_q <= charger_regs_pkg::MISC_RESET;
    end else if (wr_en_q && wr_addr_q == charger_regs_pkg::OFF_MISC) begin
      misc_q <= wr_data_q;
      // A fresh request wins over a completion in the same cycle
      misc_q[charger_regs_pkg::MISC_FORCE_DETECT_BIT] <=
        wr_data_q[charger_regs_pkg::MISC_FORCE_DETECT_BIT] |
        (misc_q[charger_regs_pkg::MISC_FORCE_DETECT_BIT] & ~done_s);
    end else if (done_s) begin
      misc_q[charger_regs_pkg::MISC_FORCE_DETECT_BIT] <= 1'b0;
    end
  end

  // Request waits for input power; the bit itself holds until detection ends
  assign port_detect_req_o = misc_q[charger_regs_pkg::MISC_FORCE_DETECT_BIT] & vbus_s;
  assign battery_switch_off_o = misc_q[charger_regs_pkg::MISC_SWITCH_OFF_BIT];

  // Safety timer slowdown: pass every other tick while limiting
  logic slow;
  logic half_q;
  logic adv_q;

  assign slow = misc_q[charger_regs_pkg::MISC_HALF_RATE_BIT] & (vin_s | iin_s | therm_s);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      half_q <= 1'b0;
      adv_q <= 1'b0;
    end else begin
      adv_q <= safety_timer_tick_i & (~slow | half_q);
      if (safety_timer_tick_i && slow) begin
        half_q <= ~half_q;
      end
    end
  end

  assign safety_timer_adv_o = adv_q;

  // Fault interrupt pulse on each newly latched fault; charge and battery overvoltage ones only when their enable bit is set
  logic int_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_q <= 1'b0;
    end else begin
      int_q <= (new_charge & misc_q[charger_regs_pkg::MISC_INT_CHARGE_BIT]) |
               (new_bat & misc_q[charger_regs_pkg::MISC_INT_BAT_BIT]) |
               new_other;
    end
  end

  assign fault_int_o = int_q;

endmodule : charger_status_fault_regs

`default_nettype wire

// *** charger_regs_pkg.sv ***
package charger_regs_pkg;

  // Register indices, also the serial pointer values
  localparam logic [7:0] OFF_MISC = 8'h07;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_FAULT = 8'h09;
  localparam logic [7:0] OFF_ID = 8'h0A;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Control register layout
  localparam logic [7:0] MISC_RESET = 8'h4B;
  localparam int MISC_FORCE_DETECT_BIT = 7;
  localparam int MISC_HALF_RATE_BIT = 6;
  localparam int MISC_SWITCH_OFF_BIT = 5;
  localparam int MISC_INT_CHARGE_BIT = 1;
  localparam int MISC_INT_BAT_BIT = 0;

  // Charge fault codes
  localparam logic [1:0] CODE_NORMAL = 2'h0;
  localparam logic [1:0] CODE_INPUT = 2'h1;
  localparam logic [1:0] CODE_TSHUT = 2'h2;
  localparam logic [1:0] CODE_TIMER = 2'h3;

  // Identification, values arbitrary
  localparam logic [2:0] PART_CODE = 3'h5;
  localparam logic [2:0] REV_CODE = 3'h2;
  localparam logic [1:0] ID_RESERVED = 2'h0;

  // Serial slave address, value arbitrary
  localparam logic [6:0] SLAVE_ADDR = 7'h5A;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int SYNC_W = 26;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PTR_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } serial_state_type;

endpackage : charger_regs_pkg

// *** sync_2ff.sv ***
`timescale 1ns/10ps
`default_nettype none

module sync_2ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : sync_2ff

`default_nettype wire

// *** fault_capture.sv ***
`timescale 1ns/10ps
`default_nettype none

module fault_capture (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Live conditions, already synchronised
  input wire logic watchdog_expired_i,
  input wire logic boost_any_fault_i,
  input wire logic input_fault_i,
  input wire logic thermal_shutdown_i,
  input wire logic timer_expired_i,
  input wire logic battery_ov_i,
  input wire logic boost_mode_i,
  input wire logic cold_buck_i,
  input wire logic hot_buck_i,
  input wire logic cold_boost_i,
  input wire logic hot_boost_i,
  input wire logic vbus_present_i,
  // Read of the fault register
  input wire logic clear_i,
  output logic [7:0] fault_o,
  // New latched faults
  output logic new_charge_o,
  output logic new_bat_o,
  output logic new_other_o
);

  logic vbus_prev_q;
  logic removed;
  logic [1:0] live_code;
  logic [1:0] ntc_live;
  logic wd_q;
  logic boost_q;
  logic [1:0] code_q;
  logic bat_q;
  logic [1:0] ntc_q;
  logic wd_d;
  logic boost_d;
  logic [1:0] code_d;
  logic bat_d;
  logic [1:0] ntc_d;

  // Unplug seen as a single-cycle event
  assign removed = vbus_prev_q & ~vbus_present_i;

  // Highest code wins when several causes coincide
  assign live_code = timer_expired_i ? charger_regs_pkg::CODE_TIMER :
                     thermal_shutdown_i ? charger_regs_pkg::CODE_TSHUT :
                     (input_fault_i | removed) ? charger_regs_pkg::CODE_INPUT :
                     charger_regs_pkg::CODE_NORMAL;

  assign ntc_live = boost_mode_i ? {cold_boost_i, hot_boost_i} : {cold_buck_i, hot_buck_i};

  // A read clears only what is gone; a live cause survives it
  assign wd_d = watchdog_expired_i | (wd_q & ~clear_i);
  assign boost_d = boost_any_fault_i | (boost_q & ~clear_i);
  assign bat_d = battery_ov_i | (bat_q & ~clear_i);
  assign ntc_d = ntc_live | (ntc_q & {2{~clear_i}});
  // First code is kept until read
  assign code_d = (clear_i || code_q == charger_regs_pkg::CODE_NORMAL) ? live_code : code_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vbus_prev_q <= 1'b0;
      wd_q <= 1'b0;
      boost_q <= 1'b0;
      code_q <= charger_regs_pkg::CODE_NORMAL;
      bat_q <= 1'b0;
      ntc_q <= 2'h0;
    end else begin
      vbus_prev_q <= vbus_present_i;
      wd_q <= wd_d;
      boost_q <= boost_d;
      code_q <= code_d;
      bat_q <= bat_d;
      ntc_q <= ntc_d;
    end
  end

  assign fault_o = {wd_q, boost_q, code_q, bat_q, 1'b0, ntc_q};
  assign new_charge_o = (code_d != charger_regs_pkg::CODE_NORMAL) && (code_d != code_q);
  assign new_bat_o = bat_d & ~bat_q;
  assign new_other_o = (wd_d & ~wd_q) | (boost_d & ~boost_q) | (|(ntc_d & ~ntc_q));

endmodule : fault_capture

`default_nettype wire

// *** charger_regs_sva.sv ***
`timescale 1ns/10ps
`default_nettype none

module charger_regs_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Analog side
  input wire logic vbus_present_i,
  input wire logic input_voltage_limit_i,
  input wire logic input_current_limit_i,
  input wire logic thermal_limit_active_i,
  input wire logic safety_timer_tick_i,
  // Controls
  input wire logic port_detect_req_o,
  input wire logic safety_timer_adv_o,
  input wire logic battery_switch_off_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Open drain: only the enable may ever move the line
  a_open_drain_low: assert property (!sda_o)
    else $error("data pin driven high");
  a_ack_clock_low: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data pulled while clock high");
  a_oe_hold_high: assert property (scl_i [*4] |-> $stable(sda_oe_o))
    else $error("data moved during clock high");
  a_reset_quiet: assert property ($rose(rst_b_i) |-> !sda_oe_o && !battery_switch_off_o && !port_detect_req_o)
    else $error("outputs not at reset values");
  a_detect_power: assert property (!vbus_present_i [*4] |-> !port_detect_req_o)
    else $error("detection requested without input power");
  a_switch_on_write: assert property ($changed(battery_switch_off_o) |-> sda_oe_o || $past(sda_oe_o) || $past(sda_oe_o, 2))
    else $error("switch control changed outside a write");
  a_adv_after_tick: assert property (safety_timer_adv_o |-> $past(safety_timer_tick_i))
    else $error("timer advanced without tick");
  a_full_rate: assert property ((!input_voltage_limit_i && !input_current_limit_i && !thermal_limit_active_i) [*4] ##0 safety_timer_tick_i |=> safety_timer_adv_o)
    else $error("timer slowed outside regulation");
endmodule : charger_regs_sva

bind charger_status_fault_regs charger_regs_sva charger_regs_sva_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .vbus_present_i(vbus_present_i), .input_voltage_limit_i(input_voltage_limit_i),
  .input_current_limit_i(input_current_limit_i),
  .thermal_limit_active_i(thermal_limit_active_i), .safety_timer_tick_i(safety_timer_tick_i),
  .port_detect_req_o(port_detect_req_o), .safety_timer_adv_o(safety_timer_adv_o),
  .battery_switch_off_o(battery_switch_off_o));
`default_nettype wire

// *** i2c_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module i2c_host_model (
  // Clock
  input wire logic clk_i,
  // Device pull-down
  input wire logic sda_oe_i,
  // Bus lines
  output logic scl_o,
  output logic sda_o
);
  logic hold_low = 1'b0;
  initial scl_o = 1'b1;
  // Pull-up: released line reads high
  assign sda_o = !(hold_low || sda_oe_i);

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : wait_clk

  // Data moves mid clock-low, sampled mid clock-high
  task automatic bit_io(input logic b, output logic r);
    wait_clk(2);
    hold_low = !b;
    wait_clk(2);
    scl_o = 1'b1;
    wait_clk(2);
    r = sda_o;
    wait_clk(2);
    scl_o = 1'b0;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, input logic m_ack, output logic [7:0] r,
                         output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(!m_ack, nak);
  endtask : byte_io

  task automatic start_cond();
    wait_clk(2);
    hold_low = 1'b0;
    wait_clk(2);
    scl_o = 1'b1;
    wait_clk(4);
    hold_low = 1'b1;
    wait_clk(4);
    scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wait_clk(2);
    hold_low = 1'b1;
    wait_clk(2);
    scl_o = 1'b1;
    wait_clk(4);
    hold_low = 1'b0;
    wait_clk(4);
  endtask : stop_cond

  task automatic write_reg(input logic [7:0] p, input logic [7:0] v, output logic nak);
    logic [7:0] r;
    logic n0, n1, n2;
    start_cond();
    byte_io({charger_regs_pkg::SLAVE_ADDR, 1'b0}, 1'b0, r, n0);
    byte_io(p, 1'b0, r, n1);
    byte_io(v, 1'b0, r, n2);
    stop_cond();
    nak = n0 | n1 | n2;
  endtask : write_reg

  // One byte per read, ended by NACK
  task automatic read_reg(input logic [7:0] p, output logic [7:0] v, output logic nak);
    logic [7:0] r;
    logic n0, n1, n2, n3;
    start_cond();
    byte_io({charger_regs_pkg::SLAVE_ADDR, 1'b0}, 1'b0, r, n0);
    byte_io(p, 1'b0, r, n1);
    start_cond();
    byte_io({charger_regs_pkg::SLAVE_ADDR, 1'b1}, 1'b0, r, n2);
    byte_io(8'hFF, 1'b0, v, n3);
    stop_cond();
    nak = n0 | n1 | n2;
  endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic scl, sda, sda_oe, req, adv, sw_off, f_int;
  logic vbus = 1'b1, done = 1'b0, tick = 1'b0, bmode = 1'b0;
  logic [1:0] src = 2'h0, ph = 2'h0;
  logic [4:0] st = 5'h00;
  logic [11:0] c = 12'h000;
  logic [7:0] v;
  int error_cnt = 0, checks = 0, int_cnt = 0, adv_cnt = 0;

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (f_int === 1'b1) int_cnt++;
    if (adv === 1'b1) adv_cnt++;
  end

  charger_status_fault_regs charger_status_fault_regs_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .input_source_type_i(src), .charge_phase_i(ph), .input_voltage_limit_i(st[4]),
    .input_current_limit_i(st[3]), .input_power_good_i(st[2]), .thermal_limit_active_i(st[1]),
    .min_system_reg_active_i(st[0]), .vbus_present_i(vbus), .port_detect_done_i(done),
    .watchdog_expired_i(c[0]), .boost_overload_i(c[1]), .vbus_ovp_i(c[2]),
    .boost_battery_low_i(c[3]), .input_fault_i(c[4]), .thermal_shutdown_i(c[5]),
    .timer_expired_i(c[6]), .battery_overvoltage_i(c[7]), .boost_mode_i(bmode),
    .cold_buck_i(c[8]), .hot_buck_i(c[9]), .cold_boost_i(c[10]), .hot_boost_i(c[11]),
    .safety_timer_tick_i(tick), .port_detect_req_o(req), .safety_timer_adv_o(adv),
    .battery_switch_off_o(sw_off), .fault_int_o(f_int));

  i2c_host_model i2c_host_model_inst (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic k;
    i2c_host_model_inst.write_reg(p, d, k);
    chk({7'h00, k}, 8'h00, "write ack");
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [7:0] exp, input string m);
    logic [7:0] d;
    logic k;
    i2c_host_model_inst.read_reg(p, d, k);
    chk({7'h00, k}, 8'h00, "read ack");
    chk(d, exp, m);
  endtask : rd

  function automatic logic [7:0] exp_status();
    return {src, ph, st[4] | st[3], st[2:0]};
  endfunction : exp_status

  function automatic logic [7:0] exp_fault(input int i);
    case (i)
      0: return 8'h80;
      1, 2, 3: return 8'h40;
      4: return 8'h10;
      5: return 8'h20;
      6: return 8'h30;
      7: return 8'h08;
      8, 10: return 8'h02;
      default: return 8'h01;
    endcase
  endfunction : exp_fault

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Whole sequence needs well under 1 ms
  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h9bdf));
    cyc(4);
    rst_b_i = 1'b1;
    cyc(4);
    rd(charger_regs_pkg::OFF_MISC, 8'h4B, "control reset");
    chk({7'h00, sw_off}, 8'h00, "switch reset");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? (8'($urandom) & 8'h7F) : (i == 1) ? 8'h6B : 8'h4B;
      wr(charger_regs_pkg::OFF_MISC, v);
      chk({7'h00, sw_off}, {7'h00, v[5]}, "switch off");
      rd(charger_regs_pkg::OFF_MISC, v, "control readback");
    end
    $display("test control done");
    wr(charger_regs_pkg::OFF_MISC, 8'hCB);
    cyc(4);
    chk({7'h00, req}, 8'h01, "detect request");
    vbus = 1'b0;
    cyc(6);
    chk({7'h00, req}, 8'h00, "detect without power");
    rd(charger_regs_pkg::OFF_FAULT, 8'h10, "removal code");
    rd(charger_regs_pkg::OFF_FAULT, 8'h00, "removal once");
    vbus = 1'b1;
    cyc(4);
    done = 1'b1;
    cyc(2);
    done = 1'b0;
    cyc(6);
    chk({7'h00, req}, 8'h00, "detect finished");
    rd(charger_regs_pkg::OFF_MISC, 8'h4B, "detect self clear");
    $display("test detect done");
    for (int i = 0; i < 6; i++) begin
      src = i[1:0];
      ph = i[1:0] + 2'h1;
      st = 5'($urandom);
      cyc(4);
      rd(charger_regs_pkg::OFF_STATUS, exp_status(), "status");
    end
    st = 5'h00;
    $display("test status done");
    for (int i = 0; i < 12; i++) begin
      v = 8'(int_cnt);
      bmode = (i >= 10);
      c[i] = 1'b1;
      cyc(8);
      c[i] = 1'b0;
      cyc(4);
      chk(8'(int_cnt) - v, 8'h01, "fault interrupt");
      rd(charger_regs_pkg::OFF_FAULT, exp_fault(i), "latched fault");
      rd(charger_regs_pkg::OFF_FAULT, 8'h00, "fault cleared");
    end
    bmode = 1'b0;
    c[7] = 1'b1;
    cyc(8);
    rd(charger_regs_pkg::OFF_FAULT, 8'h08, "first read");
    rd(charger_regs_pkg::OFF_FAULT, 8'h08, "still present");
    c[7] = 1'b0;
    cyc(4);
    rd(charger_regs_pkg::OFF_FAULT, 8'h08, "latched after cause gone");
    wr(charger_regs_pkg::OFF_MISC, 8'h48);
    c = 12'h090;
    v = 8'(int_cnt);
    cyc(8);
    c = 12'h000;
    cyc(4);
    chk(8'(int_cnt) - v, 8'h00, "masked interrupt");
    rd(charger_regs_pkg::OFF_FAULT, 8'h18, "masked faults latched");
    $display("test faults done");
    // Limit active with half rate, then no limit, then half rate off
    for (int k = 0; k < 3; k++) begin
      wr(charger_regs_pkg::OFF_MISC, (k == 2) ? 8'h0B : 8'h4B);
      st[4] = (k != 1);
      cyc(4);
      v = 8'(adv_cnt);
      repeat (4) begin
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(3);
      end
      chk(8'(adv_cnt) - v, (k == 0) ? 8'h02 : 8'h04, "timer advances");
    end
    st = 5'h00;
    $display("test timer done");
    src = 2'h2;
    wr(charger_regs_pkg::OFF_STATUS, 8'hFF);
    wr(charger_regs_pkg::OFF_FAULT, 8'hFF);
    wr(charger_regs_pkg::OFF_ID, 8'hFF);
    v = {charger_regs_pkg::PART_CODE, 2'b00, charger_regs_pkg::REV_CODE};
    rd(charger_regs_pkg::OFF_ID, v, "identification");
    rd(charger_regs_pkg::OFF_STATUS, exp_status(), "status after write");
    rd(charger_regs_pkg::OFF_FAULT, 8'h00, "fault after write");
    rd(8'h20, 8'h00, "unmapped read");
    $display("test read only done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
